/* include/asp_pkg.sv */
`default_nettype none
package asp_pkg;
  // ----------------------------------------------------------------
  // Sample word layout
  // ----------------------------------------------------------------
  localparam int NCH = 4;
  localparam int NSMP = 8;
  localparam int SW = 12;
  localparam int SW10 = 10;
  localparam int SW8 = 8;
  localparam int WORD_W = NCH * NSMP * SW;
  // ----------------------------------------------------------------
  // Lanes and frames
  // ----------------------------------------------------------------
  localparam int NLANE = 8;
  localparam int LW = 40;
  localparam int OCT_W = 8;
  localparam int FIFO_DEPTH = 16;
  // ----------------------------------------------------------------
  // Link formats and channel variants
  // ----------------------------------------------------------------
  localparam logic [3:0] FMT_1 = 4'h1;
  localparam logic [3:0] FMT_2 = 4'h2;
  localparam logic [3:0] FMT_3 = 4'h3;
  localparam logic [3:0] FMT_4 = 4'h4;
  localparam logic [3:0] FMT_5 = 4'h5;
  localparam logic [3:0] FMT_6 = 4'h6;
  localparam logic [3:0] FMT_7 = 4'h7;
  localparam logic [3:0] FMT_8 = 4'h8;
  localparam logic [3:0] FMT_9 = 4'h9;
  localparam logic [3:0] FMT_10 = 4'hA;
  localparam logic [1:0] VAR_QUAD = 2'h0;
  localparam logic [1:0] VAR_DUAL = 2'h1;
  localparam logic [1:0] VAR_SINGLE = 2'h2;
  localparam logic [2:0] OCT_1 = 3'h1;
  localparam logic [2:0] OCT_2 = 3'h2;
  localparam logic [2:0] OCT_3 = 3'h3;
  localparam logic [2:0] OCT_5 = 3'h5;
endpackage
`default_nettype wire

/* hw/asp_lane_packer.sv */
`default_nettype none

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module asp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic wr_valid,
  output logic wr_ready_r,
  input wire logic [W-1:0] wr_data,
  // Drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // Refused at elaboration, the pointers wrap only on a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("asp_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic wr_fire;
  logic rd_fire;

  assign wr_fire = wr_valid && wr_ready_r;
  assign rd_fire = rd_valid && rd_ready;
  assign rd_valid = cnt_r != '0;
  assign rd_data = mem[rp_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_fire && !rd_fire) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (rd_fire && !wr_fire) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (wr_fire) begin
      mem[wp_r] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      wr_ready_r <= 1'b0;
    end else begin
      if (wr_fire) begin
        wp_r <= wp_r + AW'(1);
      end
      if (rd_fire) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_nxt;
      // Registered so the fill side sees a clean flop
      wr_ready_r <= cnt_nxt != CW'(DEPTH);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  no_overflow_a: assert property (cnt_r == CW'(DEPTH) |-> !wr_ready_r)
    else $error("fifo full but still accepting");
endmodule

// ------------------------------------------------------------------
// Lane packer
// ------------------------------------------------------------------
module asp_lane_packer #(
  parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration
  input wire logic [3:0] link_format_select,
  input wire logic [1:0] chan_variant,
  // Sample input, sample n of channel c right-justified in 12 bits
  input wire logic smp_valid,
  output logic smp_ready_r,
  input wire logic [asp_pkg::WORD_W-1:0] smp_data,
  // Frame output, octet 0 in the top byte of each lane
  output logic frame_valid_r,
  input wire logic frame_ready,
  output logic [asp_pkg::NLANE-1:0][asp_pkg::LW-1:0] lane_data_r,
  output logic [asp_pkg::NLANE-1:0] lane_en_r,
  output logic [2:0] frame_octets_r,
  output logic fmt_err_r
);
  localparam int WW = asp_pkg::WORD_W;
  localparam int NL = asp_pkg::NLANE;
  localparam int LW = asp_pkg::LW;

  // ----------------------------------------------------------------
  // Sample pickers
  // ----------------------------------------------------------------
  function automatic int base(input int c, input int n);
    base = (c * asp_pkg::NSMP + n) * asp_pkg::SW;
  endfunction

  function automatic logic [11:0] s12(input logic [WW-1:0] w,
                                      input int c, input int n);
    s12 = w[base(c, n) +: asp_pkg::SW];
  endfunction

  function automatic logic [9:0] s10(input logic [WW-1:0] w,
                                     input int c, input int n);
    s10 = w[base(c, n) +: asp_pkg::SW10];
  endfunction

  function automatic logic [7:0] s8(input logic [WW-1:0] w,
                                    input int c, input int n);
    s8 = w[base(c, n) +: asp_pkg::SW8];
  endfunction

  // ----------------------------------------------------------------
  // Format tables
  // ----------------------------------------------------------------
  function automatic logic [3:0] lanes(input logic [3:0] f,
                                       input logic [1:0] v);
    logic q;
    logic s;
    q = v == asp_pkg::VAR_QUAD;
    s = v == asp_pkg::VAR_SINGLE;
    unique case (f)
      asp_pkg::FMT_1, asp_pkg::FMT_6: lanes = q ? 4'h6 : (s ? 4'h2 : 4'h3);
      asp_pkg::FMT_2, asp_pkg::FMT_3, asp_pkg::FMT_7, asp_pkg::FMT_8:
        lanes = q ? 4'h4 : (s ? 4'h1 : 4'h2);
      asp_pkg::FMT_4: lanes = q ? 4'h3 : (s ? 4'h1 : 4'h2);
      asp_pkg::FMT_5: lanes = q ? 4'h2 : 4'h1;
      asp_pkg::FMT_9, asp_pkg::FMT_10: lanes = q ? 4'h8 : (s ? 4'h2 : 4'h4);
      default: lanes = 4'h0;
    endcase
    if (v > asp_pkg::VAR_SINGLE) begin
      lanes = 4'h0;
    end
  endfunction

  function automatic logic [2:0] octets(input logic [3:0] f);
    unique case (f)
      asp_pkg::FMT_2, asp_pkg::FMT_7, asp_pkg::FMT_9: octets = asp_pkg::OCT_1;
      asp_pkg::FMT_3, asp_pkg::FMT_10: octets = asp_pkg::OCT_5;
      asp_pkg::FMT_8: octets = asp_pkg::OCT_3;
      default: octets = asp_pkg::OCT_2;
    endcase
  endfunction

  // Octet 0 sits at the top so each sample leaves MSB first
  function automatic logic [NL-1:0][LW-1:0] pack(input logic [WW-1:0] w,
                                                 input logic [3:0] f,
                                                 input logic [1:0] v);
    logic [NL-1:0][LW-1:0] l;
    logic [11:0] x0, x1, y0, y1;
    logic q;
    logic s;
    l = '0;
    q = v == asp_pkg::VAR_QUAD;
    s = v == asp_pkg::VAR_SINGLE;
    unique case (f)
      asp_pkg::FMT_1, asp_pkg::FMT_6: begin
        for (int g = 0; g < 2; g++) begin
          x0 = s12(w, 2 * g, 0);
          x1 = s12(w, 2 * g, 1);
          y0 = s12(w, 2 * g + 1, 0);
          y1 = s12(w, 2 * g + 1, 1);
          l[3 * g][LW-1 -: 16] = {x0, x1[11:8]};
          l[3 * g + 1][LW-1 -: 16] = {x1[7:0], s ? 8'h00 : y0[11:4]};
          l[3 * g + 2][LW-1 -: 16] = {y0[3:0], y1};
        end
      end
      asp_pkg::FMT_2, asp_pkg::FMT_7: begin
        for (int c = 0; c < asp_pkg::NCH; c++) begin
          l[c][LW-1 -: 8] = s8(w, c, 0);
        end
      end
      asp_pkg::FMT_3: begin
        for (int c = 0; c < asp_pkg::NCH; c++) begin
          l[c] = {s10(w, c, 0), s10(w, c, 1), s10(w, c, 2),
                  s10(w, c, 3)};
        end
      end
      asp_pkg::FMT_4: begin
        x0 = s12(w, 0, 0);
        x1 = s12(w, 1, 0);
        y0 = s12(w, 2, 0);
        y1 = s12(w, 3, 0);
        l[0][LW-1 -: 16] = {x0, s ? 4'h0 : x1[11:8]};
        l[1][LW-1 -: 16] = {x1[7:0], q ? y0[11:4] : 8'h00};
        l[2][LW-1 -: 16] = {y0[3:0], y1};
      end
      asp_pkg::FMT_5: begin
        l[0][LW-1 -: 16] = {s8(w, 0, 0), s ? 8'h00 : s8(w, 1, 0)};
        l[1][LW-1 -: 16] = {s8(w, 2, 0), s8(w, 3, 0)};
      end
      asp_pkg::FMT_8: begin
        for (int c = 0; c < asp_pkg::NCH; c++) begin
          l[c][LW-1 -: 24] = {s12(w, c, 0), s12(w, c, 1)};
        end
      end
      asp_pkg::FMT_9: begin
        for (int c = 0; c < asp_pkg::NCH; c++) begin
          l[2 * c][LW-1 -: 8] = s8(w, c, 0);
          l[2 * c + 1][LW-1 -: 8] = s8(w, c, 1);
        end
      end
      asp_pkg::FMT_10: begin
        for (int c = 0; c < asp_pkg::NCH; c++) begin
          l[2 * c] = {s10(w, c, 0), s10(w, c, 2), s10(w, c, 4),
                      s10(w, c, 6)};
          l[2 * c + 1] = {s10(w, c, 1), s10(w, c, 3), s10(w, c, 5),
                          s10(w, c, 7)};
        end
      end
      default: l = '0;
    endcase
    pack = l;
  endfunction

  // ----------------------------------------------------------------
  // Buffer and pop
  // ----------------------------------------------------------------
  logic buf_valid;
  logic [WW-1:0] buf_data;
  logic pop;
  logic [3:0] n_lanes;
  logic [NL-1:0] en_nxt;
  logic [NL-1:0][LW-1:0] data_nxt;

  asp_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .wr_valid(smp_valid),
    .wr_ready_r(smp_ready_r),
    .wr_data(smp_data),
    .rd_valid(buf_valid),
    .rd_ready(!frame_valid_r || frame_ready),
    .rd_data(buf_data)
  );

  // A stalled link holds the frame and backs up into the FIFO
  assign pop = buf_valid && (!frame_valid_r || frame_ready);
  assign n_lanes = lanes(link_format_select, chan_variant);

  always_comb begin
    data_nxt = pack(buf_data, link_format_select, chan_variant);
    for (int i = 0; i < NL; i++) begin
      en_nxt[i] = 4'(i) < n_lanes;
      if (!en_nxt[i]) begin
        data_nxt[i] = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_valid_r <= 1'b0;
      lane_data_r <= '0;
      lane_en_r <= '0;
      frame_octets_r <= '0;
      fmt_err_r <= 1'b0;
    end else if (pop) begin
      // Unsupported format or variant drops the word
      frame_valid_r <= n_lanes != 4'h0;
      fmt_err_r <= n_lanes == 4'h0;
      lane_data_r <= data_nxt;
      lane_en_r <= en_nxt;
      frame_octets_r <= octets(link_format_select);
    end else if (frame_ready) begin
      frame_valid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [WW-1:0] last_w;
  logic [3:0] fmt_q;
  logic [1:0] var_q;
  logic tail_bad;
  logic off_bad;

  always_ff @(posedge sys_clk) begin
    if (pop) begin
      last_w <= buf_data;
      fmt_q <= link_format_select;
      var_q <= chan_variant;
    end
  end

  always_comb begin
    tail_bad = 1'b0;
    off_bad = 1'b0;
    for (int i = 0; i < NL; i++) begin
      for (int b = 0; b < LW; b++) begin
        if (lane_data_r[i][b] && b < LW - 8 * int'(frame_octets_r)) begin
          tail_bad = 1'b1;
        end
        if (lane_data_r[i][b] && !lane_en_r[i]) begin
          off_bad = 1'b1;
        end
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  fmt1_lane0_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_1 |->
    lane_data_r[0][39:28] == s12(last_w, 0, 0))
    else $error("format 1 lane 0 does not start with A0");
  fmt6_lane2_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_6 &&
    var_q != asp_pkg::VAR_SINGLE |-> lane_data_r[2][35:24] ==
    s12(last_w, 1, 1))
    else $error("format 6 lane 2 does not carry B1");
  single_pad_a: assert property (
    frame_valid_r && var_q == asp_pkg::VAR_SINGLE &&
    (fmt_q == asp_pkg::FMT_1 || fmt_q == asp_pkg::FMT_6) |->
    lane_data_r[1][31:24] == 8'h00 && lane_en_r[1])
    else $error("single variant lane 1 pad not zero");
  fmt2_lane1_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_2 &&
    var_q != asp_pkg::VAR_SINGLE |->
    lane_data_r[1][39:32] == s8(last_w, 1, 0))
    else $error("format 2 lane 1 does not carry B0");
  fmt3_lane0_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_3 |->
    lane_data_r[0][9:0] == s10(last_w, 0, 3))
    else $error("format 3 lane 0 does not end with A3");
  fmt4_lane2_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_4 &&
    var_q == asp_pkg::VAR_QUAD |->
    lane_data_r[2][35:24] == s12(last_w, 3, 0))
    else $error("format 4 lane 2 does not end with D0");
  fmt5_pad_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_5 &&
    var_q == asp_pkg::VAR_SINGLE |-> lane_data_r[0][31:24] == 8'h00)
    else $error("format 5 single octet 1 not zero");
  fmt7_lane3_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_7 &&
    var_q == asp_pkg::VAR_QUAD |->
    lane_data_r[3][39:32] == s8(last_w, 3, 0))
    else $error("format 7 lane 3 does not carry D0");
  fmt8_lane1_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_8 &&
    var_q != asp_pkg::VAR_SINGLE |->
    lane_data_r[1][27:16] == s12(last_w, 1, 1))
    else $error("format 8 lane 1 does not carry B1");
  fmt9_lane5_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_9 &&
    var_q == asp_pkg::VAR_QUAD |->
    lane_data_r[5][39:32] == s8(last_w, 2, 1))
    else $error("format 9 lane 5 does not carry C1");
  fmt10_lane1_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_10 |->
    lane_data_r[1][9:0] == s10(last_w, 0, 7))
    else $error("format 10 lane 1 does not end with A7");
  lane_mask_a: assert property (!off_bad)
    else $error("data on a powered-down lane");
  fmt4_lane0_a: assert property (
    frame_valid_r && fmt_q == asp_pkg::FMT_4 |->
    lane_data_r[0][39:28] == s12(last_w, 0, 0))
    else $error("format 4 lane 0 does not start with A0");
  tail_zero_a: assert property (!tail_bad)
    else $error("nonzero bit past the frame octets");
  lane_low_a: assert property (
    pop |=> $onehot0({1'b0, lane_en_r} + 9'h001) &&
    (lane_en_r != '0) == frame_valid_r)
    else $error("enabled lanes not the lowest ones");
endmodule
`default_nettype wire

/* test/asp_link_rx.sv */
`default_nettype none
// ------------------------------------------------------------------
// Link receiver model, accepts frames with random back-pressure
// ------------------------------------------------------------------
module asp_link_rx (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Stall control
  input wire logic stall_all,
  input wire logic [6:0] busy_pct,
  // Frame handshake
  output logic frame_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // Decided at the edge, applied just after it like any other driver
  // Low from the first reset edge on, one driver only
  always @(posedge sys_clk) begin
    frame_ready <= #2 !rst && !stall_all &&
      ($urandom_range(99) >= busy_pct);
  end
endmodule
`default_nettype wire

/* test/asp_lane_packer_tb.sv */
`default_nettype none
module asp_lane_packer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] fmt = 4'h1;
  logic [1:0] vr = 2'h0;
  logic smp_valid = 1'b0;
  logic [383:0] smp_data = '0;
  logic smp_ready_r, frame_valid_r, frame_ready, fmt_err_r;
  logic [7:0][39:0] lane_data_r;
  logic [7:0] lane_en_r;
  logic [2:0] frame_octets_r;
  logic stall_all = 1'b0;
  logic [6:0] busy_pct = 7'h1E;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [319:0] qd[$];
  logic [7:0] qe[$];
  logic [2:0] qo[$];
  logic [383:0] qw[$];
  logic [3:0] qf[$];
  logic [383:0] cur_w;
  logic [3:0] cur_f;

  asp_lane_packer #(.FIFO_DEPTH(16)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .link_format_select(fmt),
    .chan_variant(vr), .smp_valid(smp_valid),
    .smp_ready_r(smp_ready_r), .smp_data(smp_data),
    .frame_valid_r(frame_valid_r), .frame_ready(frame_ready),
    .lane_data_r(lane_data_r), .lane_en_r(lane_en_r),
    .frame_octets_r(frame_octets_r), .fmt_err_r(fmt_err_r));
  asp_link_rx rx_u (
    .sys_clk(sys_clk), .rst(rst), .stall_all(stall_all),
    .busy_pct(busy_pct), .frame_ready(frame_ready));

  initial forever #20 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic int nlanes(logic [3:0] f, logic [1:0] v);
    int t[3];
    case (f)
      4'h1, 4'h6: t = '{6, 3, 2};
      4'h2, 4'h3, 4'h7, 4'h8: t = '{4, 2, 1};
      4'h4: t = '{3, 2, 1};
      4'h5: t = '{2, 1, 1};
      default: t = '{8, 4, 2};
    endcase
    return t[v];
  endfunction
  function automatic logic [2:0] noct(logic [3:0] f);
    case (f)
      4'h2, 4'h7, 4'h9: return 3'h1;
      4'h3, 4'hA: return 3'h5;
      4'h8: return 3'h3;
      default: return 3'h2;
    endcase
  endfunction
  function automatic logic [319:0] model(logic [3:0] f, logic [1:0] v,
                                         logic [383:0] w);
    logic [7:0][39:0] l;
    logic [11:0] a [4][8];
    bit sg;
    l = '0;
    sg = (v == 2'h2);
    for (int c = 0; c < 4; c++)
      for (int n = 0; n < 8; n++) a[c][n] = w[(c * 8 + n) * 12 +: 12];
    for (int c = 0; c < 4; c++) begin
      case (f)
        4'h1, 4'h6: if (c < 2) begin
          l[3*c] = {a[2*c][0], a[2*c][1][11:8], 24'h0};
          l[3*c+1] = {a[2*c][1][7:0],
            (sg ? 8'h00 : a[2*c+1][0][11:4]), 24'h0};
          l[3*c+2] = {a[2*c+1][0][3:0], a[2*c+1][1], 24'h0};
        end
        4'h2, 4'h7: l[c] = {a[c][0][7:0], 32'h0};
        4'h3: l[c] = {a[c][0][9:0], a[c][1][9:0],
          a[c][2][9:0], a[c][3][9:0]};
        4'h8: l[c] = {a[c][0], a[c][1], 16'h0};
        4'h9: begin
          l[2*c] = {a[c][0][7:0], 32'h0};
          l[2*c+1] = {a[c][1][7:0], 32'h0};
        end
        4'hA: for (int k = 0; k < 2; k++) l[2*c+k] = {a[c][k][9:0],
          a[c][k+2][9:0], a[c][k+4][9:0], a[c][k+6][9:0]};
        default: ;
      endcase
    end
    if (f == 4'h4) begin
      l[0] = {a[0][0], (sg ? 4'h0 : a[1][0][11:8]), 24'h0};
      l[1] = {a[1][0][7:0],
        (v == 2'h0 ? a[2][0][11:4] : 8'h00), 24'h0};
      l[2] = {a[2][0][3:0], a[3][0], 24'h0};
    end
    if (f == 4'h5) begin
      l[0] = {a[0][0][7:0], (sg ? 8'h00 : a[1][0][7:0]), 24'h0};
      l[1] = {a[2][0][7:0], a[3][0][7:0], 24'h0};
    end
    for (int i = 0; i < 8; i++) if (i >= nlanes(f, v)) l[i] = '0;
    return l;
  endfunction
  // Receiver side: merge the even and odd lane of a pair in time order
  function automatic logic [79:0] rebuild(logic [7:0][39:0] l);
    logic [79:0] r;
    for (int k = 0; k < 8; k++)
      r[79 - 10*k -: 10] = l[k % 2][39 - 10*(k / 2) -: 10];
    return r;
  endfunction
  function automatic logic [79:0] tord(logic [383:0] w);
    logic [79:0] r;
    for (int k = 0; k < 8; k++) r[79 - 10*k -: 10] = w[k*12 +: 10];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [319:0] seen,
                       input logic [319:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Expected frames queued at the take, format level held per group
  always @(posedge sys_clk) begin
    if (!rst && smp_valid && smp_ready_r === 1'b1 &&
        fmt >= 4'h1 && fmt <= 4'hA && vr != 2'h3) begin
      qd.push_back(model(fmt, vr, smp_data));
      qe.push_back(8'((1 << nlanes(fmt, vr)) - 1));
      qo.push_back(noct(fmt));
      qw.push_back(smp_data);
      qf.push_back(fmt);
    end
  end
  always @(posedge sys_clk) begin
    if (!rst && frame_valid_r === 1'b1 && frame_ready) begin
      if (qd.size() == 0) check("extra frame", 1, 0);
      else begin
        cur_w = qw.pop_front();
        cur_f = qf.pop_front();
        check("lanes", lane_data_r, qd.pop_front());
        check("lane_en", lane_en_r, qe.pop_front());
        check("octets", frame_octets_r, qo.pop_front());
        check("fmt_err", fmt_err_r, 0);
        if (cur_f == 4'hA)
          check("time order", rebuild(lane_data_r), tord(cur_w));
      end
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic burst(input int n);
    int k;
    int t;
    k = 0;
    while (k < n) begin
      for (int i = 0; i < 12; i++) smp_data[i*32 +: 32] = $urandom;
      smp_valid = ($urandom_range(3) != 0);
      t = 0;
      do begin
        @(posedge sys_clk);
        t++;
      end while (smp_valid && smp_ready_r !== 1'b1 && t < 300);
      if (t >= 300) check("take", 0, 1);
      if (smp_valid) k++;
      #2;
    end
    smp_valid = 1'b0;
  endtask
  task automatic drain();
    int t;
    t = 0;
    while ((qd.size() != 0 || frame_valid_r !== 1'b0) && t < 300) begin
      @(posedge sys_clk);
      t++;
    end
    #2;
    check("drain", qd.size(), 0);
  endtask

  initial begin
    void'($urandom(51));
    repeat (16) @(posedge sys_clk);
    #2 rst = 1'b0;
    for (int f = 1; f <= 10; f++) begin
      for (int v = 0; v < 3; v++) begin
        fmt = 4'(f);
        vr = 2'(v);
        burst(6);
        drain();
      end
    end
    // Hold the link off until the buffer refuses, then let it go
    fmt = 4'h9;
    vr = 2'h0;
    stall_all = 1'b1;
    burst(17);
    repeat (3) @(posedge sys_clk);
    #2;
    check("full ready", smp_ready_r, 0);
    check("held valid", frame_valid_r, 1);
    stall_all = 1'b0;
    busy_pct = 7'h00;
    drain();
    // Unsupported settings drop the word, a good word clears the flag
    for (int i = 0; i < 3; i++) begin
      fmt = 4'h1;
      vr = 2'h0;
      burst(1);
      drain();
      check("fmt_err clear", fmt_err_r, 0);
      fmt = (i == 0) ? 4'h0 : (i == 1) ? 4'hB : 4'h1;
      vr = (i == 2) ? 2'h3 : 2'h0;
      burst(1);
      repeat (2) @(posedge sys_clk);
      #2;
      check("fmt_err set", fmt_err_r, 1);
      check("bad en", lane_en_r, 0);
      check("bad valid", frame_valid_r, 0);
    end
    // Second reset in mid-run with traffic stalled
    fmt = 4'h2;
    vr = 2'h1;
    stall_all = 1'b1;
    burst(3);
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #2;
    qd.delete();
    qe.delete();
    qo.delete();
    qw.delete();
    qf.delete();
    check("rst ready", smp_ready_r, 0);
    check("rst valid", frame_valid_r, 0);
    check("rst en", lane_en_r, 0);
    rst = 1'b0;
    stall_all = 1'b0;
    busy_pct = 7'h32;
    burst(8);
    drain();
    summarize();
  end
endmodule
`default_nettype wire
